//--- src/irtl_pkg.sv
// Purpose: Shared constants of the infrared transmit and learning unit.
// Assumes: 100 MHz core clock, APB register access.
// Notes on behaviour
// - Output is either carrier modulated or a plain on/off level, by configuration.
// - In modulated mode hardware gates the carrier onto every on interval.
// - Envelope source is descriptors, a software bit, or the UART transmit line.
// - A descriptor holds on/off state and 1..32767 us; that state lasts exactly so.
// - Descriptors queue in a FIFO and play in order with no idle gap.
// - Receiver recognises both modulated and unmodulated detector input.
// - Receiver measures modulated carrier frequency from 10 kHz to 500 kHz.
// - Receiver reports present and absent durations interval by interval.
// - Captured intervals use the descriptor layout so they can be replayed.
package irtl_pkg;
   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned US_NS           = 1000;
   localparam int unsigned TICK_CYC        = US_NS / CLK_PERIOD_NS;
   localparam int unsigned CAR_MIN_KHZ     = 10;
   localparam int unsigned CAR_MAX_KHZ     = 500;
   localparam int unsigned CAR_MAX_PER_CYC = (1000000 / CAR_MIN_KHZ) / CLK_PERIOD_NS;
   localparam int unsigned CAR_MIN_PER_CYC = (1000000 / CAR_MAX_KHZ) / CLK_PERIOD_NS;
   // Descriptor layout, shared by transmit and learned intervals
   localparam int unsigned DUR_W   = 15;
   localparam int unsigned DESC_W  = 16;
   localparam int unsigned DESC_ST = 15;
   localparam logic [14:0] DUR_MAX = 15'h7fff;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_PRESC = 8'h04;
   localparam logic [7:0] OFS_CHALF = 8'h08;
   localparam logic [7:0] OFS_DESC  = 8'h0c;
   localparam logic [7:0] OFS_STS   = 8'h10;
   localparam logic [7:0] OFS_MASK  = 8'h14;
   localparam logic [7:0] OFS_LEVEL = 8'h18;
   localparam logic [7:0] OFS_RXIV  = 8'h1c;
   localparam logic [7:0] OFS_RXCAR = 8'h20;
   // Control fields
   localparam int unsigned CT_TXEN  = 0;
   localparam int unsigned CT_MOD   = 1;
   localparam int unsigned CT_SRC   = 2;
   localparam int unsigned CT_SWBIT = 4;
   localparam int unsigned CT_RXEN  = 5;
   localparam int unsigned CT_W     = 6;
   localparam logic [5:0]  CTRL_RST = 6'h00;
   // Status and mask bits
   localparam int unsigned ST_TXDONE = 0;
   localparam int unsigned ST_TXOVF  = 1;
   localparam int unsigned ST_RXIV   = 2;
   localparam int unsigned ST_RXOVF  = 3;
   localparam int unsigned ST_W      = 4;
   localparam logic [3:0]  MASK_RST  = 4'h0;
   // Reset values
   localparam logic [15:0] PRESC_RST = 16'(TICK_CYC - 1);
   localparam logic [15:0] CHALF_RST = 16'h0523;
   // Envelope sources
   typedef enum logic [1:0] {SRC_DESC, SRC_BIT, SRC_UART, SRC_NONE} irtl_src_e;
endpackage : irtl_pkg

//--- src/irtl_fifo.sv
// Purpose: Descriptor FIFO in flip-flops.
// Assumes: DEPTH is a power of two.
// Notes: Push when full and pop when empty are ignored.
`timescale 1ns/1ps
`default_nettype none
module irtl_fifo #(
   parameter int unsigned W     = 16,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   // Fill side
   input  wire logic          i_push,
   input  wire logic [W-1:0]  i_wdata,
   output logic               o_full,
   // Drain side
   input  wire logic          i_pop,
   output logic [W-1:0]       o_rdata,
   output logic               o_empty,
   output logic [AW:0]        o_level
);
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [AW:0]  cnt_q, cnt_d;
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic         do_push, do_pop;

   assign o_full  = (cnt_q == (AW+1)'(DEPTH));
   assign o_empty = (cnt_q == '0);
   assign o_level = cnt_q;
   assign o_rdata = mem_q[rp_q];
   assign do_push = i_push & ~o_full;
   assign do_pop  = i_pop & ~o_empty;

   always_comb begin
      mem_d = mem_q;
      if (do_push) begin
         mem_d[wp_q] = i_wdata;
      end
      wp_d  = do_push ? wp_q + 1'b1 : wp_q;
      rp_d  = do_pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_mem
         always_ff @(posedge i_clk) begin
            mem_q[g] <= mem_d[g];
         end
      end
   endgenerate
endmodule : irtl_fifo
`default_nettype wire

//--- src/irtl_rx.sv
// Purpose: Learning receiver: envelope, carrier period and interval lengths.
// Assumes: Detector input high while light or carrier is seen.
// Notes: An absence is declared TMO_CYC cycles after the last high level.
`timescale 1ns/1ps
`default_nettype none
module irtl_rx #(
   parameter int unsigned TMO_CYC = 10000
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Control
   input  wire logic        i_en,
   input  wire logic        i_tick,
   input  wire logic        i_ir,
   // Learned interval and carrier
   output logic             o_iv_vld,
   output logic [15:0]      o_iv,
   output logic [15:0]      o_car_per,
   output logic             o_car_mod
);
   logic [2:0]  sy_q;
   logic        filt_q, filt_d, env_q, env_d, seen_q, seen_d, rise;
   logic [15:0] ecnt_q, ecnt_d, lcnt_q, lcnt_d, per_q, per_d;
   logic [14:0] dur_q, dur_d;
   logic        vld_d;
   logic [15:0] iv_d;
   localparam logic [14:0] DUR_MAX_L = irtl_pkg::DUR_MAX;

   always_comb begin
      filt_d = (sy_q[1] == sy_q[2]) ? sy_q[2] : filt_q;
      rise   = filt_d & ~filt_q;
      ecnt_d = rise ? 16'h0000 : ((ecnt_q == 16'hffff) ? ecnt_q : ecnt_q + 16'h0001);
      lcnt_d = filt_d ? 16'h0000 : ((lcnt_q == 16'hffff) ? lcnt_q : lcnt_q + 16'h0001);
      env_d  = env_q;
      per_d  = per_q;
      seen_d = seen_q;
      if (rise) begin
         env_d = 1'b1;
         if (env_q && ecnt_q < 16'(TMO_CYC)) begin
            per_d  = ecnt_q + 16'h0001;
            seen_d = 1'b1;
         end
      end else if (lcnt_q == 16'(TMO_CYC)) begin
         env_d = 1'b0;
      end
      dur_d = (i_tick && dur_q != DUR_MAX_L) ? dur_q + 15'h0001 : dur_q;
      vld_d = 1'b0;
      iv_d  = {env_q, dur_q};
      if (env_d != env_q) begin
         vld_d = 1'b1;
         dur_d = 15'h0000;
         if (env_d) begin
            seen_d = 1'b0;
         end
      end
      if (!i_en) begin
         env_d  = 1'b0;
         dur_d  = 15'h0000;
         vld_d  = 1'b0;
         seen_d = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sy_q      <= 3'h0;
         filt_q    <= 1'b0;
         env_q     <= 1'b0;
         seen_q    <= 1'b0;
         ecnt_q    <= 16'hffff;
         lcnt_q    <= 16'hffff;
         per_q     <= 16'h0000;
         dur_q     <= 15'h0000;
         o_iv_vld  <= 1'b0;
         o_iv      <= 16'h0000;
      end else begin
         sy_q      <= {sy_q[1:0], i_ir};
         filt_q    <= filt_d;
         env_q     <= env_d;
         seen_q    <= seen_d;
         ecnt_q    <= ecnt_d;
         lcnt_q    <= lcnt_d;
         per_q     <= per_d;
         dur_q     <= dur_d;
         o_iv_vld  <= vld_d;
         o_iv      <= vld_d ? iv_d : o_iv;
      end
   end
   assign o_car_per = per_q;
   assign o_car_mod = seen_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_env_rises:  assert property (i_en && rise |=> env_q)
      else $error("envelope did not rise on input edge");
   a_iv_report:  assert property (i_en && (env_d != env_q) |=>
                                  o_iv_vld && o_iv[15] == !env_q)
      else $error("interval not reported on envelope change");
   a_car_period: assert property (i_en && rise && env_q && ecnt_q < 16'(TMO_CYC) |=>
                                  per_q == $past(ecnt_q) + 16'h0001 && seen_q)
      else $error("carrier period not captured");
   c_mod_burst:  cover property (seen_q && o_iv_vld);
endmodule : irtl_rx
`default_nettype wire

//--- src/irtl_top.sv
// Purpose: Infrared transmit modulator and learning receiver with APB registers.
// Assumes: Single 100 MHz clock; zero-wait APB with registered read data.
// Notes: Status bits are sticky, cleared by writing one; set wins over clear.
`timescale 1ns/1ps
`default_nettype none
module irtl_top #(
   parameter int unsigned FIFO_DEPTH = 8,
   parameter int unsigned RX_TMO_CYC = irtl_pkg::CAR_MAX_PER_CYC
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Pins
   input  wire logic        i_uart_txd,
   input  wire logic        i_ir_rx,
   output logic             o_ir_tx,
   // Interrupt
   output logic             o_irq
);
   localparam int unsigned FAW = $clog2(FIFO_DEPTH);
   typedef enum logic {TX_IDLE, TX_PLAY} irtl_tx_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and APB
   logic [irtl_pkg::CT_W-1:0] ctrl_q, ctrl_d;
   logic [15:0]               presc_q, presc_d, chalf_q, chalf_d;
   logic [irtl_pkg::ST_W-1:0] sts_q, sts_d, mask_q, mask_d, ev;
   logic [15:0]               ivr_q, ivr_d;
   logic                      ivv_q, ivv_d;
   logic [31:0]               rdata_d;
   logic                      ready_d, err_d, irq_d, mapped;
   logic                      wr_acc, rd_acc, setup;
   logic                      tx_en, mod_en, sw_bit, rx_en, desc_mode;
   irtl_pkg::irtl_src_e       src;
   logic                      fifo_full, fifo_empty, fifo_pop, fifo_push;
   logic [15:0]               fifo_rdata;
   logic [FAW:0]              fifo_level;
   logic                      iv_vld, car_mod;
   logic [15:0]               iv_data, car_per;
   irtl_tx_e                  tx_st_q, tx_st_d;
   logic [14:0]               dur_q, dur_d;
   logic                      lvl_q, lvl_d, tx_done, restart;
   logic [15:0]               pcnt_q, pcnt_d, ccnt_q, ccnt_d;
   logic                      tick_q, tick_d, cph_q, cph_d, env, ir_d;
   logic [2:0]                usy_q;
   logic                      uart_q, uart_d;

   assign setup  = i_psel & ~i_penable;
   assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
   assign rd_acc = i_psel & i_penable & o_pready & ~i_pwrite;
   assign tx_en  = ctrl_q[irtl_pkg::CT_TXEN];
   assign mod_en = ctrl_q[irtl_pkg::CT_MOD];
   assign sw_bit = ctrl_q[irtl_pkg::CT_SWBIT];
   assign rx_en  = ctrl_q[irtl_pkg::CT_RXEN];
   assign src    = irtl_pkg::irtl_src_e'(ctrl_q[irtl_pkg::CT_SRC +: 2]);
   assign desc_mode = tx_en && (src == irtl_pkg::SRC_DESC);
   assign fifo_push = wr_acc && (i_paddr == irtl_pkg::OFS_DESC) && !fifo_full;

   always_comb begin
      mapped  = 1'b1;
      rdata_d = 32'h0000_0000;
      case (i_paddr)
         irtl_pkg::OFS_CTRL:  rdata_d = 32'(ctrl_q);
         irtl_pkg::OFS_PRESC: rdata_d = 32'(presc_q);
         irtl_pkg::OFS_CHALF: rdata_d = 32'(chalf_q);
         irtl_pkg::OFS_DESC:  rdata_d = 32'h0000_0000;
         irtl_pkg::OFS_STS:   rdata_d = 32'(sts_q);
         irtl_pkg::OFS_MASK:  rdata_d = 32'(mask_q);
         irtl_pkg::OFS_LEVEL: rdata_d = {15'h0000, (tx_st_q == TX_PLAY), 16'(fifo_level)};
         irtl_pkg::OFS_RXIV:  rdata_d = {15'h0000, ivv_q, ivr_q};
         irtl_pkg::OFS_RXCAR: rdata_d = {15'h0000, car_mod, car_per};
         default:             mapped  = 1'b0;
      endcase
      ready_d = setup;
      err_d   = setup && !mapped;
      ctrl_d  = ctrl_q;
      presc_d = presc_q;
      chalf_d = chalf_q;
      mask_d  = mask_q;
      sts_d   = sts_q;
      if (wr_acc) begin
         case (i_paddr)
            irtl_pkg::OFS_CTRL:  ctrl_d  = i_pwdata[irtl_pkg::CT_W-1:0];
            irtl_pkg::OFS_PRESC: presc_d = i_pwdata[15:0];
            irtl_pkg::OFS_CHALF: chalf_d = i_pwdata[15:0];
            irtl_pkg::OFS_STS:   sts_d   = sts_q & ~i_pwdata[irtl_pkg::ST_W-1:0];
            irtl_pkg::OFS_MASK:  mask_d  = i_pwdata[irtl_pkg::ST_W-1:0];
            default:             ctrl_d  = ctrl_q;
         endcase
      end
      sts_d = sts_d | ev;
      ivv_d = (rd_acc && i_paddr == irtl_pkg::OFS_RXIV) ? 1'b0 : ivv_q;
      ivr_d = ivr_q;
      if (iv_vld) begin
         ivv_d = 1'b1;
         ivr_d = iv_data;
      end
      irq_d = |(sts_d & mask_d);
   end

   always_comb begin
      ev = '0;
      ev[irtl_pkg::ST_TXDONE] = tx_done;
      ev[irtl_pkg::ST_TXOVF]  = wr_acc && (i_paddr == irtl_pkg::OFS_DESC) && fifo_full;
      ev[irtl_pkg::ST_RXIV]   = iv_vld;
      ev[irtl_pkg::ST_RXOVF]  = iv_vld && ivv_q && !(rd_acc && i_paddr == irtl_pkg::OFS_RXIV);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ctrl_q    <= irtl_pkg::CTRL_RST;
         presc_q   <= irtl_pkg::PRESC_RST;
         chalf_q   <= irtl_pkg::CHALF_RST;
         sts_q     <= '0;
         mask_q    <= irtl_pkg::MASK_RST;
         ivr_q     <= 16'h0000;
         ivv_q     <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_irq     <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         presc_q   <= presc_d;
         chalf_q   <= chalf_d;
         sts_q     <= sts_d;
         mask_q    <= mask_d;
         ivr_q     <= ivr_d;
         ivv_q     <= ivv_d;
         o_prdata  <= setup ? rdata_d : 32'h0000_0000;
         o_pready  <= ready_d;
         o_pslverr <= err_d;
         o_irq     <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Descriptor FIFO and learning receiver
   irtl_fifo #(
      .W     (irtl_pkg::DESC_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk   (i_ref_clk),
      .i_rst   (i_sys_rst),
      .i_push  (fifo_push),
      .i_wdata (i_pwdata[15:0]),
      .o_full  (fifo_full),
      .i_pop   (fifo_pop),
      .o_rdata (fifo_rdata),
      .o_empty (fifo_empty),
      .o_level (fifo_level)
   );

   irtl_rx #(
      .TMO_CYC (RX_TMO_CYC)
   ) u_rx (
      .i_clk     (i_ref_clk),
      .i_rst     (i_sys_rst),
      .i_en      (rx_en),
      .i_tick    (tick_q),
      .i_ir      (i_ir_rx),
      .o_iv_vld  (iv_vld),
      .o_iv      (iv_data),
      .o_car_per (car_per),
      .o_car_mod (car_mod)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Microsecond tick, descriptor player, carrier and output

   always_comb begin
      tx_st_d  = tx_st_q;
      dur_d    = dur_q;
      lvl_d    = lvl_q;
      fifo_pop = 1'b0;
      tx_done  = 1'b0;
      restart  = 1'b0;
      case (tx_st_q)
         TX_IDLE: begin
            if (desc_mode && !fifo_empty) begin
               fifo_pop = 1'b1;
               restart  = 1'b1;
               lvl_d    = fifo_rdata[irtl_pkg::DESC_ST];
               dur_d    = fifo_rdata[14:0];
               tx_st_d  = TX_PLAY;
            end
         end
         TX_PLAY: begin
            if (!desc_mode) begin
               tx_st_d = TX_IDLE;
               lvl_d   = 1'b0;
            end else if (tick_q) begin
               if (dur_q > 15'h0001) begin
                  dur_d = dur_q - 15'h0001;
               end else if (!fifo_empty) begin
                  fifo_pop = 1'b1;
                  lvl_d    = fifo_rdata[irtl_pkg::DESC_ST];
                  dur_d    = fifo_rdata[14:0];
               end else begin
                  tx_st_d = TX_IDLE;
                  lvl_d   = 1'b0;
                  tx_done = 1'b1;
               end
            end
         end
         default: tx_st_d = TX_IDLE;
      endcase
      // Restart aligns the first tick so the first interval matches the rest
      if (restart) begin
         tick_d = (presc_q == 16'h0000);
         pcnt_d = (presc_q == 16'h0000) ? 16'h0000 : presc_q - 16'h0001;
      end else begin
         tick_d = (pcnt_q == 16'h0000);
         pcnt_d = (pcnt_q == 16'h0000) ? presc_q : pcnt_q - 16'h0001;
      end
      uart_d = (usy_q[1] == usy_q[2]) ? usy_q[2] : uart_q;
      case (src)
         irtl_pkg::SRC_DESC: env = lvl_q;
         irtl_pkg::SRC_BIT:  env = sw_bit;
         irtl_pkg::SRC_UART: env = ~uart_q;
         default:            env = 1'b0;
      endcase
      if (!env) begin
         ccnt_d = chalf_q;
         cph_d  = 1'b1;
      end else if (ccnt_q == 16'h0000) begin
         ccnt_d = chalf_q;
         cph_d  = ~cph_q;
      end else begin
         ccnt_d = ccnt_q - 16'h0001;
         cph_d  = cph_q;
      end
      ir_d = tx_en && env && (!mod_en || cph_q);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         tx_st_q <= TX_IDLE;
         dur_q   <= 15'h0000;
         lvl_q   <= 1'b0;
         pcnt_q  <= 16'h0000;
         tick_q  <= 1'b0;
         ccnt_q  <= 16'h0000;
         cph_q   <= 1'b1;
         usy_q   <= 3'h7;
         uart_q  <= 1'b1;
         o_ir_tx <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         dur_q   <= dur_d;
         lvl_q   <= lvl_d;
         pcnt_q  <= pcnt_d;
         tick_q  <= tick_d;
         ccnt_q  <= ccnt_d;
         cph_q   <= cph_d;
         usy_q   <= {usy_q[1:0], i_uart_txd};
         uart_q  <= uart_d;
         o_ir_tx <= ir_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_apb_ready:    assert property (setup |=> o_pready ##1 !o_pready)
      else $error("pready not one cycle after setup");
   a_apb_unmapped: assert property (setup && !mapped |=> o_pready && o_pslverr)
      else $error("unmapped address not flagged");
   a_plain_level:  assert property (tx_en && !mod_en && src == irtl_pkg::SRC_BIT |=>
                                    o_ir_tx == $past(sw_bit))
      else $error("unmodulated output does not follow bit");
   a_carrier_off:  assert property (!env |=> !o_ir_tx)
      else $error("output on outside an on interval");
   a_carrier_tgl:  assert property (env && mod_en && ccnt_q == 16'h0000 |=>
                                    cph_q != $past(cph_q))
      else $error("carrier phase did not toggle");
   a_dur_count:    assert property (tx_st_q == TX_PLAY && desc_mode && tick_q && dur_q > 15'h0001
                                    |=> dur_q == $past(dur_q) - 15'h0001 && $stable(lvl_q))
      else $error("interval count wrong");
   a_no_gap:       assert property (tx_st_q == TX_PLAY && desc_mode && tick_q && dur_q <= 15'h0001
                                    && !fifo_empty |=> tx_st_q == TX_PLAY)
      else $error("gap between descriptors");
   a_tick_period:  assert property (restart && presc_q == 16'h0001 |=> !tick_q ##1 tick_q)
      else $error("first tick after restart misplaced");
   a_ovf_flag:     assert property (wr_acc && i_paddr == irtl_pkg::OFS_DESC && fifo_full
                                    |=> sts_q[irtl_pkg::ST_TXOVF])
      else $error("descriptor overflow not flagged");
   a_irq_level:    assert property (|(sts_q & mask_q) && $past(|(sts_q & mask_q)) |-> o_irq)
      else $error("interrupt low with unmasked status");
   c_play_chain:   cover property (fifo_pop && tx_st_q == TX_PLAY);
   c_done:         cover property (tx_done ##[1:20] o_irq);
   c_mod_out:      cover property (mod_en && o_ir_tx ##1 !o_ir_tx);
   c_learn:        cover property (iv_vld && rx_en);
endmodule : irtl_top
`default_nettype wire

//--- dv/irtl_ir_model.sv
// Purpose: Emitter and detector pair facing the infrared unit.
// Assumes: Detector sees the emitter one cycle late when looped.
// Notes: Dark detector reads low, as a real photodiode stage would.
`timescale 1ns/1ps
`default_nettype none
module irtl_ir_model (
   // Optical path
   input  wire logic i_clk,
   input  wire logic i_led,
   input  wire logic i_loop,
   output logic      o_det
);
   logic led_q;
   always_ff @(posedge i_clk) begin
      led_q <= i_led;
   end
   assign o_det = i_loop & led_q;
endmodule : irtl_ir_model
`default_nettype wire

//--- dv/infrared_tx_and_learning_test.sv
// Purpose: Self-checking bench for the infrared unit.
// Assumes: Prescaler set to 2 cycles per us; RX timeout 300 cycles.
// Notes: Learned intervals come from the emitter via the loop model.
`timescale 1ns/1ps
`default_nettype none
module infrared_tx_and_learning_test;
   logic        clk, rst, psel, penable, pwrite, uart, ir_rx, ir_tx, irq, pready, pslverr, e, p;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   int          errors, cmp_count, n;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c};
   logic [31:0] rv [7] = '{32'h0, 32'h63, 32'h523, 32'h0, 32'h0, 32'h0, 32'h0};
   irtl_top #(.FIFO_DEPTH(8), .RX_TMO_CYC(300)) dut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_uart_txd(uart), .i_ir_rx(ir_rx),
      .o_ir_tx(ir_tx), .o_irq(irq));
   irtl_ir_model model (.i_clk(clk), .i_led(ir_tx), .i_loop(1'b1), .o_det(ir_rx));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      cmp_count++;
      if (s !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r, output logic er);
      int k;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) errors++;
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] r;
      logic        er;
      apb(1, a, wd, r, er);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic er;
      apb(0, a, 0, r, er);
   endtask : rd
   task automatic run(input logic v, output int c);
      int k;
      k = 0;
      c = 0;
      while (ir_tx !== v && k < 3000) begin @(posedge clk); k++; end
      while (ir_tx === v && c < 3000) begin @(posedge clk); c++; end
   endtask : run
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      cyc(20000);
      errors++;
      close_out();
   end
   initial begin
      rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; uart = 1;
      errors = 0; cmp_count = 0; p = 0;
      cyc(10);
      rst <= 0;
      for (int i = 0; i < 7; i++) begin
         rd(ra[i], d);
         chk("reset value", d, rv[i]);
      end
      apb(0, 8'h40, 0, d, e);
      chk("unmapped error", e, 1);
      chk("unmapped data", d, 0);
      $display("test registers done");
      wr(8'h04, 1);
      wr(8'h0c, 32'h8003); wr(8'h0c, 32'h0002); wr(8'h0c, 32'h8001);
      wr(8'h00, 1);
      run(1, n); chk("on 3us", n, 6);
      run(0, n); chk("off 2us", n, 4);
      run(1, n); chk("on 1us", n, 2);
      rd(8'h10, d); chk("drain status", d[0], 1);
      wr(8'h00, 0); wr(8'h10, 32'hf); wr(8'h08, 1); wr(8'h0c, 32'h8008); wr(8'h00, 3);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         n += int'(ir_tx === 1'b1 && p !== 1'b1);
         p = ir_tx;
      end
      chk("carrier bursts", n, 4);
      $display("test transmit done");
      wr(8'h00, 32'h15); cyc(4); chk("bit on", ir_tx, 1);
      wr(8'h00, 32'h05); cyc(4); chk("bit off", ir_tx, 0);
      wr(8'h00, 32'h09); uart <= 0; cyc(8); chk("uart low", ir_tx, 1);
      uart <= 1; cyc(8); chk("uart idle", ir_tx, 0);
      wr(8'h00, 32'h1d); uart <= 0; cyc(8); chk("source off", ir_tx, 0);
      uart <= 1;
      $display("test sources done");
      wr(8'h08, 32'd99); wr(8'h10, 32'hf); wr(8'h00, 32'h35); cyc(20);
      rd(8'h1c, d); chk("absent record", d[16:15], 2'b10);
      cyc(980); wr(8'h00, 32'h25); cyc(400);
      rd(8'h1c, d); chk("present record", d[16:15], 2'b11);
      chk("present length", (d[14:0] >= 15'd645) && (d[14:0] <= 15'd665), 1);
      wr(8'h00, 0); wr(8'h0c, {16'h0, d[15:0]}); wr(8'h00, 1);
      run(1, n); chk("replayed length", n, {16'h0, d[14:0], 1'b0});
      wr(8'h00, 32'h37); cyc(1000);
      rd(8'h20, d); chk("carrier period", d[16:0], 17'h100c8);
      $display("test learning done");
      wr(8'h00, 0); wr(8'h10, 32'hf);
      repeat (9) wr(8'h0c, 32'h8001);
      rd(8'h18, d); chk("fifo level", d[16:0], 17'h8);
      rd(8'h10, d); chk("overflow status", d[1], 1);
      chk("irq masked", irq, 0);
      wr(8'h14, 2); cyc(2); chk("irq raised", irq, 1);
      wr(8'h10, 2); cyc(2); chk("irq cleared", irq, 0);
      rst <= 1; cyc(2); rst <= 0;
      rd(8'h18, d); chk("level after reset", d, 0);
      chk("irq after reset", irq, 0);
      $display("test overflow and reset done");
      close_out();
   end
endmodule : infrared_tx_and_learning_test
`default_nettype wire
